//--- include/dcbuf_pkg.sv
/*
 * Shared constants of the differential clock buffer control block:
 * register offsets, field positions, reset values, timing counts, states.
 * Assumes a 100 MHz pclk.
 */
`default_nettype none
package dcbuf_pkg;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int STOP_RESUME_NS = 15;
   localparam int WAKE_RESUME_US = 300;
   localparam int LOCK_TIME_US = 100;
   localparam int STOP_RESUME_CYC = (STOP_RESUME_NS / CLK_PERIOD_NS < 1) ? 1 : STOP_RESUME_NS / CLK_PERIOD_NS;
   localparam int WAKE_RESUME_CYC = WAKE_RESUME_US * 1000 / CLK_PERIOD_NS;
   localparam int LOCK_CYC = LOCK_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int NUM_PAIRS = 8;
   localparam int CNT_W = 16;
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] STATUS_OFS = 12'h004;
   localparam int CTRL_HALF_BIT = 0;
   localparam int CTRL_ZERO_DELAY_BIT = 1;
   localparam int CTRL_BW_BIT = 2;
   localparam int CTRL_OE_LSB = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000FF01;
   localparam int STAT_LOCK_BIT = 0;
   localparam int STAT_POL_BIT = 1;
   localparam int STAT_STATE_LSB = 2;
   localparam int STAT_STOP_BIT = 5;
   localparam int STAT_OE_LSB = 8;
   // ------------------------------------------------------------
   // power state
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_DOWN = 3'h1,
      ST_WAKE = 3'h2,
      ST_RUN = 3'h4
   } dcbuf_state_type;
endpackage
`default_nettype wire

//--- src/dcbuf_sync.sv
/*
 * Two-flop synchroniser for a group of independent pin levels.
 * Assumes each bit is a slow level; no bus coherency across bits.
 */
`default_nettype none
module dcbuf_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= '0;
         q_ff <= '0;
      end else begin
         meta_ff <= d;
         q_ff <= meta_ff;
      end
   end

   assign q = q_ff;
endmodule // dcbuf_sync

//--- src/dcbuf_ctrl.sv
/*
 * Output control of an eight-pair differential clock buffer, with an APB
 * register slave for frequency, mode, bandwidth and per-pair enables.
 * Assumes pins are asynchronous levels and the reference clock is well
 * below pclk/2 so that it can be sampled.
 */
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`default_nettype none
module dcbuf_ctrl
   import dcbuf_pkg::*;
#(
   parameter int POWER_WAKE_CYC = WAKE_RESUME_CYC,
   parameter int PLL_LOCK_CYC = LOCK_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ref_clock_in_true,
   input wire logic ref_clock_in_comp,
   input wire logic enable_polarity_select,
   input wire logic power_down_n,
   input wire logic output_stop_n,
   output logic [NUM_PAIRS-1:0] diff_out_true,
   output logic [NUM_PAIRS-1:0] diff_out_comp,
   output logic [NUM_PAIRS-1:0] diff_out_oe,
   output logic lock_out,
   output logic zero_delay_active,
   output logic loop_bw_low
);
   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [4:0] pins_s;
   logic ref_t_s;
   logic ref_c_s;
   logic pol_s;
   logic pwr_s;
   logic stop_s;

   dcbuf_sync #(.W(5)) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d({ref_clock_in_true, ref_clock_in_comp, enable_polarity_select, power_down_n, output_stop_n}),
      .q(pins_s)
   );

   assign {ref_t_s, ref_c_s, pol_s, pwr_s, stop_s} = pins_s;

   // pin level to "asserted" under a given polarity
   function automatic logic asserted_low(input logic pol, input logic lvl);
      asserted_low = pol ? lvl : ~lvl;
   endfunction

   // ------------------------------------------------------------
   // registers and state
   // ------------------------------------------------------------
   logic [31:0] ctrl_ff;
   logic pol_ff;
   dcbuf_state_type st_ff;
   dcbuf_state_type nxt_st;
   logic [CNT_W-1:0] wake_cnt_ff;
   logic [CNT_W-1:0] lock_cnt_ff;
   logic ref_d_ff;
   logic clk_q_ff;
   logic [NUM_PAIRS-1:0] oe_ff;
   logic [NUM_PAIRS-1:0] true_ff;
   logic [NUM_PAIRS-1:0] comp_ff;
   logic lock_ff;
   logic zero_delay_ff;
   logic bw_low_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic [1:0] mode_d_ff;

   logic ref_s;
   logic pwr_live;
   logic pwr_act;
   logic stop_act;
   logic half_n;
   logic [NUM_PAIRS-1:0] en_vec;
   logic apb_done;
   logic hit_ctrl;
   logic hit_stat;

   assign ref_s = ref_t_s & ~ref_c_s;
   assign pwr_live = asserted_low(pol_s, pwr_s);
   assign pwr_act = asserted_low(pol_ff, pwr_s);
   assign stop_act = asserted_low(pol_ff, stop_s);
   assign half_n = ctrl_ff[CTRL_HALF_BIT];

   // ------------------------------------------------------------
   // power state machine
   // ------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         ST_DOWN: begin
            if (!pwr_live) begin
               nxt_st = ST_WAKE;
            end
         end
         // two sync edges, entry edge and output flop must fit the resume bound
         ST_WAKE: begin
            if (pwr_act) begin
               nxt_st = ST_DOWN;
            end else if (wake_cnt_ff >= CNT_W'(POWER_WAKE_CYC - 5)) begin
               nxt_st = ST_RUN;
            end
         end
         ST_RUN: begin
            if (pwr_act) begin
               nxt_st = ST_DOWN;
            end
         end
         default: begin
            nxt_st = ST_DOWN;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= ST_DOWN;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // polarity latched on leaving power-down only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pol_ff <= 1'b0;
      end else if (st_ff == ST_DOWN && !pwr_live) begin
         pol_ff <= pol_s;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_cnt_ff <= '0;
      end else if (st_ff != ST_WAKE) begin
         wake_cnt_ff <= '0;
      end else begin
         wake_cnt_ff <= wake_cnt_ff + 1'b1;
      end
   end

   // ------------------------------------------------------------
   // loop model: lock after settle time in zero-delay mode
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_d_ff <= 2'h0;
         lock_cnt_ff <= '0;
         lock_ff <= 1'b0;
      end else begin
         mode_d_ff <= {ctrl_ff[CTRL_BW_BIT], ctrl_ff[CTRL_ZERO_DELAY_BIT]};
         if (st_ff == ST_DOWN || !ctrl_ff[CTRL_ZERO_DELAY_BIT] ||
             mode_d_ff != {ctrl_ff[CTRL_BW_BIT], ctrl_ff[CTRL_ZERO_DELAY_BIT]}) begin
            lock_cnt_ff <= '0;
            lock_ff <= 1'b0;
         end else if (lock_cnt_ff >= CNT_W'(PLL_LOCK_CYC - 1)) begin
            lock_ff <= 1'b1;
         end else begin
            lock_cnt_ff <= lock_cnt_ff + 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         zero_delay_ff <= 1'b0;
         bw_low_ff <= 1'b0;
      end else begin
         zero_delay_ff <= ctrl_ff[CTRL_ZERO_DELAY_BIT];
         bw_low_ff <= ctrl_ff[CTRL_BW_BIT];
      end
   end

   // ------------------------------------------------------------
   // output clock and pair drivers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_d_ff <= 1'b0;
         clk_q_ff <= 1'b0;
      end else begin
         ref_d_ff <= ref_s;
         if (st_ff == ST_DOWN) begin
            clk_q_ff <= 1'b0;
         end else if (half_n) begin
            clk_q_ff <= ref_s;
         end else if (ref_s && !ref_d_ff) begin
            clk_q_ff <= ~clk_q_ff;
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PAIRS; gi++) begin : g_pair
         assign en_vec[gi] = pol_ff ? ~ctrl_ff[CTRL_OE_LSB + gi] : ctrl_ff[CTRL_OE_LSB + gi];
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               oe_ff[gi] <= 1'b0;
               true_ff[gi] <= 1'b0;
               comp_ff[gi] <= 1'b1;
            end else begin
               oe_ff[gi] <= (st_ff == ST_RUN) && !stop_act && en_vec[gi];
               true_ff[gi] <= clk_q_ff;
               comp_ff[gi] <= ~clk_q_ff;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // apb slave, one wait state
   // ------------------------------------------------------------
   assign apb_done = psel && penable && pready_ff;
   assign hit_ctrl = paddr == CTRL_OFS;
   assign hit_stat = paddr == STATUS_OFS;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h00000000;
      end else begin
         pready_ff <= psel && penable && !pready_ff;
         pslverr_ff <= psel && penable && !pready_ff && !hit_ctrl && !hit_stat;
         prdata_ff <= 32'h00000000;
         if (psel && penable && !pready_ff && !pwrite) begin
            if (hit_ctrl) begin
               prdata_ff <= ctrl_ff;
            end else if (hit_stat) begin
               prdata_ff[STAT_LOCK_BIT] <= lock_ff;
               prdata_ff[STAT_POL_BIT] <= pol_ff;
               prdata_ff[STAT_STATE_LSB +: 3] <= st_ff;
               prdata_ff[STAT_STOP_BIT] <= stop_act;
               prdata_ff[STAT_OE_LSB +: NUM_PAIRS] <= oe_ff;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= CTRL_RESET;
      end else if (apb_done && pwrite && hit_ctrl) begin
         ctrl_ff <= pwdata & 32'h0000FF07;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign diff_out_true = true_ff;
   assign diff_out_comp = comp_ff;
   assign diff_out_oe = oe_ff;
   assign lock_out = lock_ff;
   assign zero_delay_active = zero_delay_ff;
   assign loop_bw_low = bw_low_ff;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_oe_high_drive: assert property (
      st_ff == ST_RUN && !stop_act && !pol_ff && ctrl_ff[CTRL_OE_LSB] |=> diff_out_oe[0])
      else $error("pair 0 not driving with high enable");
   a_oe_low_tristate: assert property (
      pol_ff && ctrl_ff[CTRL_OE_LSB + 1] |=> !diff_out_oe[1])
      else $error("pair 1 driven with low enable deasserted");
   a_stop_undriven: assert property (
      stop_act |=> diff_out_oe == '0)
      else $error("outputs driven during stop");
   a_down_undriven: assert property (
      st_ff == ST_RUN && pwr_act |=> st_ff == ST_DOWN ##1 diff_out_oe == '0)
      else $error("power-down did not tri-state outputs");
   a_stop_resume: assert property (
      st_ff == ST_RUN && !stop_act && pwr_s == !pol_ff && |en_vec |=> |diff_out_oe)
      else $error("outputs late after stop release");
   a_wake_bound: assert property (
      st_ff == ST_WAKE |-> wake_cnt_ff < CNT_W'(POWER_WAKE_CYC - 4))
      else $error("wake exceeded resume time");
   a_pol_held: assert property (
      st_ff != ST_DOWN |=> $stable(pol_ff))
      else $error("polarity changed outside power-down");
   a_lock_cause: assert property (
      $rose(lock_out) |-> zero_delay_ff && $past(st_ff) != ST_DOWN && lock_cnt_ff >= CNT_W'(PLL_LOCK_CYC - 1))
      else $error("lock without settle in zero-delay mode");
   a_bypass_unlocked: assert property (
      !ctrl_ff[CTRL_ZERO_DELAY_BIT] |=> !lock_out)
      else $error("lock reported in bypass mode");
   a_down_unlocked: assert property (
      st_ff == ST_DOWN |=> !lock_out)
      else $error("lock reported during power-down");
   a_full_freq: assert property (
      st_ff != ST_DOWN && half_n |=> clk_q_ff == $past(ref_s))
      else $error("full rate clock does not follow input");
   a_half_freq: assert property (
      st_ff != ST_DOWN && !half_n && ref_s && !ref_d_ff |=> clk_q_ff != $past(clk_q_ff))
      else $error("half rate clock did not toggle");
   a_pair_compl: assert property (
      diff_out_true == ~diff_out_comp)
      else $error("true and complement not opposite");
   a_mode_follow: assert property (
      ##1 zero_delay_active == $past(ctrl_ff[CTRL_ZERO_DELAY_BIT]) && loop_bw_low == $past(ctrl_ff[CTRL_BW_BIT]))
      else $error("mode or bandwidth output stale");

   c_reach_run: cover property (st_ff == ST_WAKE ##1 st_ff == ST_RUN);
   c_locked: cover property ($rose(lock_out));
   c_stop_cycle: cover property ($rose(stop_act) ##[1:20] $fell(stop_act));
   c_low_pol_run: cover property (pol_ff && st_ff == ST_RUN && |diff_out_oe);
   c_half_rate: cover property (!half_n && $rose(clk_q_ff));
endmodule // dcbuf_ctrl
`default_nettype wire

//--- verif/dcbuf_ref_gen.sv
/*
 * Main clock generator model: a free-running differential reference clock.
 * Assumes HALF_NS keeps the reference well below pclk/2.
 */
`default_nettype none
module dcbuf_ref_gen #(
   parameter int HALF_NS = 40
) (
   output logic ref_true,
   output logic ref_comp
);
   timeunit 1ns;
   timeprecision 1ps;
   // complementary pair, runs free as the generator does
   initial begin
      ref_true = 1'b0;
      forever #(HALF_NS) ref_true = ~ref_true;
   end
   assign ref_comp = ~ref_true;
endmodule // dcbuf_ref_gen
`default_nettype wire

//--- verif/testbench.sv
/*
 * Self-checking bench of the buffer control block: APB tasks, pin stimulus.
 * Assumes shortened wake and lock counts, and a 100 MHz pclk.
 */
`default_nettype none
module testbench
   import dcbuf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WAKE = 20;
   localparam int LOCKC = 10;
   localparam int LIMIT = 30000;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic ref_t, ref_c, strap, pwr_n, stop_n, lock_out, zd_on, bwl;
   logic [NUM_PAIRS-1:0] d_t, d_c, oe;
   int mismatches, n_checks, cyc;

   dcbuf_ref_gen i_dcbuf_ref_gen (.ref_true(ref_t), .ref_comp(ref_c));
   dcbuf_ctrl #(.POWER_WAKE_CYC(WAKE), .PLL_LOCK_CYC(LOCKC)) i_dcbuf_ctrl (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ref_clock_in_true(ref_t), .ref_clock_in_comp(ref_c), .enable_polarity_select(strap),
      .power_down_n(pwr_n), .output_stop_n(stop_n), .diff_out_true(d_t), .diff_out_comp(d_c),
      .diff_out_oe(oe), .lock_out(lock_out), .zero_delay_active(zd_on), .loop_bw_low(bwl));

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic results;
      if (mismatches == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_oe(input logic [7:0] exp, input int lim);
      int n;
      n = 0;
      while (oe !== exp && n < lim) begin
         @(posedge pclk);
         n++;
      end
      chk({24'h0, oe}, {24'h0, exp});
   endtask

   // rises of pair 0 against reference rises, two edges of slack each way
   task automatic freq(input int div);
      int nr, no;
      logic pr, po;
      nr = 0;
      no = 0;
      pr = ref_t;
      po = d_t[0];
      repeat (1600) begin
         @(posedge pclk);
         if (ref_t && !pr) nr++;
         if (d_t[0] && !po) no++;
         pr = ref_t;
         po = d_t[0];
      end
      chk({31'h0, (no * div + 2 >= nr) && (no * div <= nr + 2)}, 32'h1);
      chk({24'h0, d_c}, {24'h0, ~d_t});
   endtask

   // ------------------------------------------------------------
   // clock, timeout, sequence
   // ------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cyc++;
      if (cyc == LIMIT) begin
         mismatches++;
         results();
      end
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      strap = 1'b0;
      pwr_n = 1'b0;
      stop_n = 1'b1;
      mismatches = 0;
      n_checks = 0;
      cyc = 0;
      repeat (16) @(posedge pclk);
      chk({24'h0, oe}, 32'h0);
      presetn <= 1'b1;
      apb(1'b0, CTRL_OFS, 32'h0); chk(rd, 32'h0000FF01);
      apb(1'b0, STATUS_OFS, 32'h0); chk(rd, 32'h00000004);
      apb(1'b1, STATUS_OFS, 32'hFFFFFFFF);
      apb(1'b0, STATUS_OFS, 32'h0); chk(rd, 32'h00000004);
      apb(1'b0, 12'h010, 32'h0); chk({31'h0, err}, 32'h1);
      pwr_n <= 1'b1;
      wait_oe(8'hFF, WAKE + 5);
      freq(1);
      apb(1'b1, CTRL_OFS, 32'h0000A500);
      wait_oe(8'hA5, 4);
      freq(2);
      @(posedge pclk);
      stop_n <= 1'b0;
      wait_oe(8'h00, 4);
      @(posedge pclk);
      stop_n <= 1'b1;
      wait_oe(8'hA5, 4);
      apb(1'b1, CTRL_OFS, 32'h0000A503);
      repeat (LOCKC + 20) @(posedge pclk);
      chk({30'h0, zd_on, lock_out}, 32'h3);
      apb(1'b1, CTRL_OFS, 32'h0000A507);
      repeat (3) @(posedge pclk);
      chk({29'h0, zd_on, bwl, lock_out}, 32'h6);
      @(posedge pclk);
      pwr_n <= 1'b0;
      wait_oe(8'h00, 6);
      @(posedge pclk);
      strap <= 1'b1;
      stop_n <= 1'b0;
      wait_oe(8'h5A, WAKE + 8);
      apb(1'b0, STATUS_OFS, 32'h0); chk({31'h0, rd[1]}, 32'h1);
      strap <= 1'b0;
      repeat (5) @(posedge pclk);
      apb(1'b0, STATUS_OFS, 32'h0); chk({31'h0, rd[1]}, 32'h1);
      chk({24'h0, oe}, 32'h0000005A);
      @(posedge pclk);
      stop_n <= 1'b1;
      wait_oe(8'h00, 4);
      @(posedge pclk);
      stop_n <= 1'b0;
      wait_oe(8'h5A, 4);
      @(posedge pclk);
      pwr_n <= 1'b1;
      wait_oe(8'h00, 6);
      results();
   end
endmodule // testbench
`default_nettype wire
